//--- verilog/interrupt_pkg.sv
// Constants shared by the interrupt arbiter and its testbench
package interrupt_pkg;
   // ==================================================
   // Source numbering
   localparam int NUM_SRC = 29;
   localparam int SRC_W = 5;
   localparam int NUM_PIN = 5;
   localparam int NUM_KEY = 6;
   localparam int NUM_PERIPH = 20;
   localparam int SRC_LOW_VOLT = 0;
   localparam int SRC_KEY_RETURN = 20;
   localparam int SRC_RTC = 21;
   localparam int SRC_TWO_WIRE = 24;
   localparam int SRC_SERIAL_CH1 = 25;
   localparam int PIN_SRC [NUM_PIN] = '{22, 23, 26, 27, 28};
   localparam int PIN_FIRST = 7;
   localparam int NUM_EDGE_BITS = 12;

   // ==================================================
   // Vector addresses
   localparam logic [15:0] VEC_MASKABLE_BASE = 16'h0004;
   localparam logic [15:0] VEC_BRK = 16'h003e;
   localparam logic [15:0] VEC_RESET = 16'h0000;

   // ==================================================
   // Register byte offsets
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_REQUEST = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_PRIORITY = 8'h08;
   localparam logic [7:0] OFS_RISE = 8'h0c;
   localparam logic [7:0] OFS_FALL = 8'h10;
   localparam logic [7:0] OFS_PSW = 8'h14;
   localparam logic [7:0] OFS_KEY_MODE = 8'h18;
   localparam logic [7:0] OFS_LOW_VOLT = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   localparam logic [7:0] OFS_VECTOR = 8'h28;

   // ==================================================
   // Reset values and field positions
   localparam logic [28:0] MASK_RST = 29'h1fffffff;
   localparam logic [28:0] PRIORITY_RST = 29'h1fffffff;
   localparam logic [7:0] PSW_RST = 8'h02;
   localparam int PSW_IE_BIT = 7;
   localparam int PSW_ISP_BIT = 1;
   localparam int LOW_VOLT_RESET_SEL_BIT = 1;
   localparam int NUM_STATUS = 3;
   localparam int ST_TAKEN = 0;
   localparam int ST_RESET = 1;
   localparam int ST_BRK = 2;
   localparam logic [2:0] IRQ_MASK_RST = 3'h7;
endpackage

//--- verilog/edge_sync.sv
// Pin synchroniser with per-bit rising and falling edge detection
`timescale 1ns/1ps
module edge_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pins and enables
   input wire logic [W-1:0] pin_in,
   input wire logic [W-1:0] rise_en,
   input wire logic [W-1:0] fall_en,
   // Results
   output logic [W-1:0] level,
   output logic [W-1:0] edge_pulse
);
   logic [W-1:0] meta;
   logic [W-1:0] prev;

   // ==================================================
   // Per-bit synchroniser and edge detect
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta[i] <= 1'b1;
               level[i] <= 1'b1;
               prev[i] <= 1'b1;
            end else begin
               meta[i] <= pin_in[i];
               level[i] <= meta[i];
               prev[i] <= level[i];
            end
         end
         assign edge_pulse[i] = (rise_en[i] & level[i] & ~prev[i]) | (fall_en[i] & ~level[i] & prev[i]);
      end
   endgenerate
endmodule

//--- verilog/vectored_interrupt_arbiter.sv
// Maskable, software and reset interrupt arbitration with vector output
`timescale 1ns/1ps
// Functional notes
// - Simultaneous maskable requests are served high priority first, lowest level number first within a priority.
// - Key return request is level 20, vector 002CH, keys chosen by mode register.
// - Real-time counter cycle or alarm raises level 21, vector 002EH.
// - Pin edges 7 to 11 are levels 22,23,26,27,28 with two-byte vectors.
// - Two-wire serial completion raises level 24, vector 0034H.
// - Second clocked serial channel completion raises level 25, vector 0036H.
// - Reset pin, power-on, watchdog and selected low voltage vector to 0000H.
// - Control via request, mask, priority, rising, falling edge and status word registers.
// - Rising and falling edge detection are enabled independently per pin.
// - Acceptance needs global enable besides mask and priority; low-priority sources also need the in-service flag.
// - Each source owns one request, mask and priority bit by source number.
module vectored_interrupt_arbiter (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral events, same clock
   input wire logic [19:0] periph_event,
   input wire logic rtc_cycle_event,
   input wire logic rtc_alarm_event,
   input wire logic two_wire_done_event,
   input wire logic serial_ch1_done_event,
   // External pins
   input wire logic [4:0] pin_edge_in,
   input wire logic [5:0] key_return_in,
   input wire logic reset_pin_n,
   // Reset sources, same clock
   input wire logic power_on_clear,
   input wire logic low_voltage_detect,
   input wire logic watchdog_overflow,
   // Processor core
   input wire logic brk_request,
   input wire logic int_ack,
   output logic int_request,
   output logic [15:0] int_vector,
   output logic reset_request,
   // Interrupt line
   output logic irq
);
   logic [28:0] request_flag;
   logic [28:0] mask_flag;
   logic [28:0] priority_flag;
   logic [11:0] rising_edge_enable;
   logic [11:0] falling_edge_enable;
   logic [7:0] program_status_word;
   logic [5:0] key_return_mode_reg;
   logic [7:0] low_voltage_control_reg;
   logic [2:0] status;
   logic [2:0] irq_mask;
   logic brk_pending;
   logic [4:0] pend_src;
   logic pend_maskable;
   logic [4:0] pin_pulse;
   logic [5:0] key_pulse;
   logic [0:0] reset_pin_level;
   logic key_return_request;
   logic rtc_cycle_alarm_request;
   logic two_wire_done_request;
   logic serial_ch1_done_request;
   logic [4:0] pin_edge_request;
   logic low_voltage_reset_select;
   logic global_enable_flag;
   logic in_service_level_flag;
   logic [28:0] hw_set;
   logic [28:0] eligible;
   logic [28:0] ack_clear;
   logic sel_found;
   logic [4:0] sel_src;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;
   logic [31:0] read_mux;
   logic [2:0] ev;
   logic [2:0] rd_clear;
   logic [15:0] next_vector;
   logic next_request;

   // ==================================================
   // Pin synchronisers and edge detection
   edge_sync #(.W(interrupt_pkg::NUM_PIN)) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(pin_edge_in),
      .rise_en(rising_edge_enable[11:7]),
      .fall_en(falling_edge_enable[11:7]),
      .level(),
      .edge_pulse(pin_pulse)
   );

   edge_sync #(.W(interrupt_pkg::NUM_KEY)) u_key_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(key_return_in),
      .rise_en(6'h00),
      .fall_en(key_return_mode_reg),
      .level(),
      .edge_pulse(key_pulse)
   );

   edge_sync #(.W(1)) u_reset_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(reset_pin_n),
      .rise_en(1'b0),
      .fall_en(1'b0),
      .level(reset_pin_level),
      .edge_pulse()
   );

   // ==================================================
   // Request sources
   assign low_voltage_reset_select = low_voltage_control_reg[interrupt_pkg::LOW_VOLT_RESET_SEL_BIT];
   assign key_return_request = |key_pulse;
   assign rtc_cycle_alarm_request = rtc_cycle_event | rtc_alarm_event;
   assign two_wire_done_request = two_wire_done_event;
   assign serial_ch1_done_request = serial_ch1_done_event;
   assign pin_edge_request = pin_pulse;
   assign reset_request = ~reset_pin_level[0] | power_on_clear | watchdog_overflow |
                          (low_voltage_detect & low_voltage_reset_select);
   assign global_enable_flag = program_status_word[interrupt_pkg::PSW_IE_BIT];
   assign in_service_level_flag = program_status_word[interrupt_pkg::PSW_ISP_BIT];

   always_comb begin
      hw_set = {9'h000, periph_event};
      hw_set[interrupt_pkg::SRC_LOW_VOLT] = periph_event[0] | (low_voltage_detect & ~low_voltage_reset_select);
      hw_set[interrupt_pkg::SRC_KEY_RETURN] = key_return_request;
      hw_set[interrupt_pkg::SRC_RTC] = rtc_cycle_alarm_request;
      hw_set[interrupt_pkg::SRC_TWO_WIRE] = two_wire_done_request;
      hw_set[interrupt_pkg::SRC_SERIAL_CH1] = serial_ch1_done_request;
      for (int p = 0; p < interrupt_pkg::NUM_PIN; p++) begin
         hw_set[interrupt_pkg::PIN_SRC[p]] = pin_edge_request[p];
      end
   end

   // ==================================================
   // Acceptance and fixed-order selection
   always_comb begin
      for (int s = 0; s < interrupt_pkg::NUM_SRC; s++) begin
         // High level always, low level only with no high level in service
         eligible[s] = request_flag[s] & ~mask_flag[s] & global_enable_flag &
                       (~priority_flag[s] | in_service_level_flag);
      end
   end

   always_comb begin
      sel_found = 1'b0;
      sel_src = 5'h00;
      // High-level sources first, lowest number wins within a level
      for (int s = interrupt_pkg::NUM_SRC - 1; s >= 0; s--) begin
         if (eligible[s] && !priority_flag[s]) begin
            sel_found = 1'b1;
            sel_src = 5'(s);
         end
      end
      if (!sel_found) begin
         for (int s = interrupt_pkg::NUM_SRC - 1; s >= 0; s--) begin
            if (eligible[s]) begin
               sel_found = 1'b1;
               sel_src = 5'(s);
            end
         end
      end
   end

   always_comb begin
      next_request = 1'b0;
      next_vector = interrupt_pkg::VEC_RESET;
      if (reset_request) begin
         next_vector = interrupt_pkg::VEC_RESET;
      end else if (brk_pending && !int_ack) begin
         next_request = 1'b1;
         next_vector = interrupt_pkg::VEC_BRK;
      end else if (sel_found && !int_ack) begin
         next_request = 1'b1;
         next_vector = interrupt_pkg::VEC_MASKABLE_BASE + 16'({sel_src, 1'b0});
      end
   end

   // ==================================================
   // Core handshake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_request <= 1'b0;
         int_vector <= interrupt_pkg::VEC_RESET;
         pend_src <= 5'h00;
         pend_maskable <= 1'b0;
      end else begin
         int_request <= next_request;
         int_vector <= next_vector;
         pend_src <= sel_src;
         pend_maskable <= next_request & ~brk_pending;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_pending <= 1'b0;
      end else if (brk_request) begin
         brk_pending <= 1'b1;
      end else if (int_ack && int_request && !pend_maskable) begin
         brk_pending <= 1'b0;
      end
   end

   always_comb begin
      ack_clear = 29'h00000000;
      if (int_ack && int_request && pend_maskable) begin
         ack_clear[pend_src] = 1'b1;
      end
   end

   // ==================================================
   // APB decode
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= interrupt_pkg::OFS_VECTOR);
   assign pslverr = psel & penable & ~addr_ok;

   always_comb begin
      read_mux = 32'h00000000;
      case (paddr)
         interrupt_pkg::OFS_REQUEST: read_mux = {3'h0, request_flag};
         interrupt_pkg::OFS_MASK: read_mux = {3'h0, mask_flag};
         interrupt_pkg::OFS_PRIORITY: read_mux = {3'h0, priority_flag};
         interrupt_pkg::OFS_RISE: read_mux = {20'h00000, rising_edge_enable};
         interrupt_pkg::OFS_FALL: read_mux = {20'h00000, falling_edge_enable};
         interrupt_pkg::OFS_PSW: read_mux = {24'h000000, program_status_word};
         interrupt_pkg::OFS_KEY_MODE: read_mux = {26'h0000000, key_return_mode_reg};
         interrupt_pkg::OFS_LOW_VOLT: read_mux = {24'h000000, low_voltage_control_reg};
         interrupt_pkg::OFS_STATUS: read_mux = {29'h00000000, status};
         interrupt_pkg::OFS_IRQ_MASK: read_mux = {29'h00000000, irq_mask};
         interrupt_pkg::OFS_VECTOR: read_mux = {15'h0000, int_request, int_vector};
         default: read_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= read_mux;
      end
   end

   // ==================================================
   // Flag registers, hardware set wins over any clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         request_flag <= 29'h00000000;
      end else if (wr_en && paddr == interrupt_pkg::OFS_REQUEST) begin
         request_flag <= (pwdata[28:0] & ~ack_clear) | hw_set;
      end else begin
         request_flag <= (request_flag & ~ack_clear) | hw_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_flag <= interrupt_pkg::MASK_RST;
         priority_flag <= interrupt_pkg::PRIORITY_RST;
         rising_edge_enable <= 12'h000;
         falling_edge_enable <= 12'h000;
         key_return_mode_reg <= 6'h00;
         low_voltage_control_reg <= 8'h00;
      end else if (wr_en) begin
         case (paddr)
            interrupt_pkg::OFS_MASK: mask_flag <= pwdata[28:0];
            interrupt_pkg::OFS_PRIORITY: priority_flag <= pwdata[28:0];
            interrupt_pkg::OFS_RISE: rising_edge_enable <= pwdata[11:0];
            interrupt_pkg::OFS_FALL: falling_edge_enable <= pwdata[11:0];
            interrupt_pkg::OFS_KEY_MODE: key_return_mode_reg <= pwdata[5:0];
            interrupt_pkg::OFS_LOW_VOLT: low_voltage_control_reg <= pwdata[7:0];
            default: mask_flag <= mask_flag;
         endcase
      end
   end

   // Status word: acceptance drops enable and records a high-level entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_status_word <= interrupt_pkg::PSW_RST;
      end else if (int_ack && int_request) begin
         program_status_word[interrupt_pkg::PSW_IE_BIT] <= 1'b0;
         if (pend_maskable && !priority_flag[pend_src]) begin
            program_status_word[interrupt_pkg::PSW_ISP_BIT] <= 1'b0;
         end
      end else if (wr_en && paddr == interrupt_pkg::OFS_PSW) begin
         program_status_word <= pwdata[7:0];
      end
   end

   // ==================================================
   // Event status, read clears, set wins
   assign ev[interrupt_pkg::ST_TAKEN] = int_ack & int_request & pend_maskable;
   assign ev[interrupt_pkg::ST_RESET] = reset_request;
   assign ev[interrupt_pkg::ST_BRK] = brk_request;
   // Clear only what the setup phase captured, so a later event survives
   assign rd_clear = (psel && penable && !pwrite && paddr == interrupt_pkg::OFS_STATUS) ? prdata[2:0] : 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 3'h0;
      end else begin
         status <= (status & ~rd_clear) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= interrupt_pkg::IRQ_MASK_RST;
      end else if (wr_en && paddr == interrupt_pkg::OFS_IRQ_MASK) begin
         irq_mask <= pwdata[2:0];
      end
   end

   assign irq = |(status & ~irq_mask);
endmodule

//--- tb/vectored_interrupt_arbiter_properties.sv
// Port-level checks for the interrupt arbiter
`timescale 1ns/1ps
module vectored_interrupt_arbiter_properties (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Reset sources
   input wire logic reset_pin_n,
   input wire logic power_on_clear,
   input wire logic watchdog_overflow,
   // Core side
   input wire logic int_ack,
   input wire logic int_request,
   input wire logic [15:0] int_vector,
   input wire logic reset_request
);
   // ==================================================
   // Assertions
   a_ready_always: assert property (@(posedge pclk) disable iff (!presetn) pready)
      else $error("pready low");
   a_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h28)) |-> pslverr) else $error("no slave error");
   a_error_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      (!(psel && penable) || (paddr[1:0] == 2'h0 && paddr <= 8'h28)) |-> !pslverr) else $error("stray slave error");
   a_vector_range: assert property (@(posedge pclk) disable iff (!presetn)
      int_request |-> (int_vector[0] == 1'b0 && int_vector >= 16'h0004 && int_vector <= 16'h003e))
      else $error("vector out of table");
   a_reset_forces: assert property (@(posedge pclk) disable iff (!presetn)
      reset_request |=> (!int_request && int_vector == 16'h0000)) else $error("reset vector not forced");
   a_reset_sources: assert property (@(posedge pclk) disable iff (!presetn)
      (power_on_clear || watchdog_overflow) |-> reset_request) else $error("reset source ignored");
   a_reset_pin: assert property (@(posedge pclk) disable iff (!presetn)
      !reset_pin_n [*3] |-> reset_request) else $error("reset pin ignored");
   a_ack_releases: assert property (@(posedge pclk) disable iff (!presetn)
      (int_request && int_ack && !reset_request) |=> !int_request) else $error("request kept after ack");
   a_request_stands: assert property (@(posedge pclk) disable iff (!presetn)
      (int_request && !int_ack && !reset_request) |=> int_request) else $error("request dropped");
endmodule

bind vectored_interrupt_arbiter vectored_interrupt_arbiter_properties vectored_interrupt_arbiter_properties_inst (
   .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .reset_pin_n, .power_on_clear,
   .watchdog_overflow, .int_ack, .int_request, .int_vector, .reset_request);

//--- tb/core_model.sv
// Processor core model that accepts interrupt vectors
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Arbiter side
   input wire logic int_request,
   input wire logic [15:0] int_vector,
   input wire logic [3:0] ack_delay,
   output logic int_ack,
   // Record of accepted vectors
   output logic [15:0] last_vector,
   output logic [7:0] ack_count
);
   logic [3:0] wait_cnt;
   // ==================================================
   // Acceptance after a programmable delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_ack <= 1'b0;
         wait_cnt <= 4'h0;
         last_vector <= 16'h0000;
         ack_count <= 8'h00;
      end else if (int_ack || !int_request) begin
         int_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (wait_cnt >= ack_delay) begin
         int_ack <= 1'b1;
         last_vector <= int_vector;
         ack_count <= ack_count + 8'h01;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule

//--- tb/vectored_interrupt_arbiter_tb.sv
// Self-checking bench for the interrupt arbiter
`timescale 1ns/1ps
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module vectored_interrupt_arbiter_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [19:0] periph_event;
   logic rtc_cycle_event, rtc_alarm_event, two_wire_done_event, serial_ch1_done_event;
   logic [4:0] pin_edge_in;
   logic [5:0] key_return_in;
   logic reset_pin_n, power_on_clear, low_voltage_detect, watchdog_overflow;
   logic brk_request, int_ack, int_request, reset_request, irq;
   logic [15:0] int_vector, last_vector;
   logic [7:0] ack_count;
   logic [3:0] ack_delay;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] ofs_tab [10] = '{interrupt_pkg::OFS_MASK, interrupt_pkg::OFS_PRIORITY, interrupt_pkg::OFS_RISE,
      interrupt_pkg::OFS_FALL, interrupt_pkg::OFS_PSW, interrupt_pkg::OFS_KEY_MODE, interrupt_pkg::OFS_LOW_VOLT,
      interrupt_pkg::OFS_IRQ_MASK, interrupt_pkg::OFS_VECTOR, interrupt_pkg::OFS_REQUEST};
   logic [31:0] rst_tab [10] = '{32'h1fffffff, 32'h1fffffff, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0};
   logic [15:0] order_tab [5] = '{16'h003c, 16'h000a, 16'h002e, 16'h0034, 16'h0036};
   logic [15:0] pin_tab [5] = '{16'h0030, 16'h0032, 16'h0038, 16'h003a, 16'h003c};

   // ==================================================
   // Design and core model
   vectored_interrupt_arbiter vectored_interrupt_arbiter_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .periph_event, .rtc_cycle_event, .rtc_alarm_event, .two_wire_done_event,
      .serial_ch1_done_event, .pin_edge_in, .key_return_in, .reset_pin_n, .power_on_clear, .low_voltage_detect,
      .watchdog_overflow, .brk_request, .int_ack, .int_request, .int_vector, .reset_request, .irq);
   core_model core_model_inst (.pclk, .presetn, .int_request, .int_vector, .ack_delay, .int_ack, .last_vector,
      .ack_count);

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // ==================================================
   // Tasks
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata,
      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] d;
      logic e;
      apb(1'b1, addr, data, d, e);
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
      logic [31:0] d;
      logic e;
      apb(1'b0, addr, 32'h0, d, e);
      `CHECK(d, exp)
      `CHECK(e, exp_err)
   endtask

   task automatic serve(input logic [15:0] exp);
      logic [7:0] n;
      n = ack_count;
      for (int i = 0; i < 100 && ack_count == n; i++) @(posedge pclk);
      `CHECK(ack_count, n + 8'h01)
      `CHECK(last_vector, exp)
      wr(interrupt_pkg::OFS_PSW, 32'h82);
   endtask

   task automatic complete_run;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         complete_run;
      end
   end

   // ==================================================
   // Scenarios
   initial begin
      {psel, penable, pwrite, paddr, pwdata, periph_event} = '0;
      {rtc_cycle_event, rtc_alarm_event, two_wire_done_event, serial_ch1_done_event} = '0;
      {power_on_clear, low_voltage_detect, watchdog_overflow, brk_request} = '0;
      pin_edge_in = 5'h1f;
      key_return_in = 6'h3f;
      reset_pin_n = 1'b1;
      ack_delay = 4'h0;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++) rd_chk(ofs_tab[i], rst_tab[i], 1'b0);
      rd_chk(8'h2c, 32'h0, 1'b1);
      rd_chk(8'h06, 32'h0, 1'b1);
      wr(interrupt_pkg::OFS_MASK, 32'h0);
      wr(interrupt_pkg::OFS_PRIORITY, 32'h0fffffff);
      wr(interrupt_pkg::OFS_FALL, 32'h800);
      @(posedge pclk);
      {periph_event[3], rtc_cycle_event, two_wire_done_event, serial_ch1_done_event} <= 4'hf;
      pin_edge_in[4] <= 1'b0;
      @(posedge pclk);
      {periph_event[3], rtc_cycle_event, two_wire_done_event, serial_ch1_done_event} <= 4'h0;
      repeat (6) @(posedge pclk);
      `CHECK(int_request, 1'b0)
      rd_chk(interrupt_pkg::OFS_REQUEST, 32'h13200008, 1'b0);
      wr(interrupt_pkg::OFS_PSW, 32'h82);
      for (int i = 0; i < 5; i++) serve(order_tab[i]);
      wr(interrupt_pkg::OFS_FALL, 32'h0);
      wr(interrupt_pkg::OFS_KEY_MODE, 32'h1);
      ack_delay <= 4'h5;
      key_return_in[0] <= 1'b0;
      serve(16'h002c);
      rtc_alarm_event <= 1'b1;
      @(posedge pclk);
      rtc_alarm_event <= 1'b0;
      serve(16'h002e);
      for (int j = 0; j < 5; j++) begin
         wr(interrupt_pkg::OFS_RISE, 32'h80 << j);
         pin_edge_in[j] <= 1'b0;
         repeat (5) @(posedge pclk);
         pin_edge_in[j] <= 1'b1;
         serve(pin_tab[j]);
      end
      brk_request <= 1'b1;
      @(posedge pclk);
      brk_request <= 1'b0;
      serve(16'h003e);
      low_voltage_detect <= 1'b1;
      @(posedge pclk);
      `CHECK(reset_request, 1'b0)
      low_voltage_detect <= 1'b0;
      @(posedge pclk);
      serve(16'h0004);
      wr(interrupt_pkg::OFS_REQUEST, 32'h00000002);
      serve(16'h0006);
      wr(interrupt_pkg::OFS_LOW_VOLT, 32'h2);
      for (int k = 0; k < 4; k++) begin
         low_voltage_detect <= (k == 0);
         power_on_clear <= (k == 1);
         watchdog_overflow <= (k == 2);
         reset_pin_n <= (k != 3);
         repeat (4) @(posedge pclk);
         `CHECK(reset_request, 1'b1)
         {low_voltage_detect, power_on_clear, watchdog_overflow, reset_pin_n} <= 4'h1;
         repeat (4) @(posedge pclk);
         `CHECK(reset_request, 1'b0)
      end
      `CHECK(irq, 1'b0)
      wr(interrupt_pkg::OFS_IRQ_MASK, 32'h0);
      @(posedge pclk);
      `CHECK(irq, 1'b1)
      rd_chk(interrupt_pkg::OFS_STATUS, 32'h7, 1'b0);
      @(posedge pclk);
      `CHECK(irq, 1'b0)
      rd_chk(interrupt_pkg::OFS_STATUS, 32'h0, 1'b0);
      complete_run;
   end
endmodule
